/* verilog/pmc_map.svh */
// Register map, field positions, reset values and timing constants of the power management control block
//
// Notes on behaviour
// - Reference-hold bit 15 keeps the analog reference on during transceiver reset; resets to 0.
// - With the reference switched off, wait about 100 ms before transceiver counts as operational.
// - Reference-hold and oscillator-keep bits survive a guarded reset only while reset protection is on.
// - Bit 14 zero gives normal crystal driver, one keeps the oscillator always running.
// - Oscillator-keep set stops oscillator shutdown in deepest suspend and unpowered state.
// - Bit 13 lets the energy-efficient wake flag act as a wakeup event; resets to 0.
// - Energy-efficient wake enable self-clears at resume end when resume-clears-enables is set.
// - Bit 12 flags energy-efficient wake, sets regardless of enable, write-one-clear, resets 0.
// - Resume-clears-status set clears the energy-efficient wake flag when a resume completes.
// - Bit 11 high holds MAC receive and transmit domains in reset until software clears it.
// - MAC domain resets release only while the matching domain clock is running.
// - Bit 9 set clears listed wake status flags at resume end; clear keeps them.
// - Bit 9 also clears the upper wake-cause bit and energy-efficient flag at resume end.
// - Automatic status clearing only follows remote-wake resumes, never host-initiated ones.
// - Bit 8 resets to 1 and clears all wake enables after remote-wake resumes only.
// - Bit 7 is a read-only ready flag, resets to 0, high only when device is ready.
// - Ready stays low until the transceiver reset sequence ends and it is operational.
// - Ready stays low while configuration contents load from external or one-time storage.
// - Bits 6:5 pick suspend level zero to three; field resets to 10b.
// - Entering the unconfigured state returns the suspend-level field to 10b.
// - Suspend levels zero and one behave identically.
// - Transceiver reset hold extends to 128 ms when the analog reference is switched off.
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH

// ----------------------------------------------------------------
// Register offset
// ----------------------------------------------------------------
`define PMC_CTL_OFFSET 32'h0000_0014

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PMC_HOLD_REF_BIT 15
`define PMC_OSC_KEEP_BIT 14
`define PMC_EEE_EN_BIT 13
`define PMC_EEE_FLAG_BIT 12
`define PMC_MAC_RST_BIT 11
`define PMC_CLR_FLAGS_BIT 9
`define PMC_CLR_EN_BIT 8
`define PMC_READY_BIT 7
`define PMC_LEVEL_HI 6
`define PMC_LEVEL_LO 5

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PMC_HOLD_REF_RST 1'b0
`define PMC_OSC_KEEP_RST 1'b1
`define PMC_EEE_EN_RST 1'b0
`define PMC_EEE_FLAG_RST 1'b0
`define PMC_MAC_RST_RST 1'b0
`define PMC_CLR_FLAGS_RST 1'b0
`define PMC_CLR_EN_RST 1'b1
`define PMC_READY_RST 1'b0
`define PMC_LEVEL_RST 2'h2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PMC_CLK_PERIOD_NS 5
`define PMC_NS_PER_MS 1000000
`define PMC_HOLD_SHORT_MS 4
`define PMC_HOLD_LONG_MS 128
`define PMC_SETTLE_MS 100

`endif

/* verilog/pmc_pkg.sv */
// Types shared by the power management control block
package pmc_pkg;

    typedef enum logic [1:0] {
        sleep_level_zero,
        sleep_level_one,
        sleep_level_two,
        sleep_level_three
    } sleep_level_t;

    typedef enum logic [1:0] {
        xcvr_hold,
        xcvr_settle,
        xcvr_run
    } xcvr_state_t;

    // Writable control fields of the register
    typedef struct packed {
        logic hold_analog_ref_on;
        logic oscillator_keep_running;
        logic energy_eff_wake_enable;
        logic energy_eff_wake_flag;
        logic mac_domain_reset;
        logic resume_clears_wake_flags;
        logic resume_clears_wake_enables;
        sleep_level_t sleep_level;
    } ctl_fields_t;

    // One-cycle requests to the wake control registers at the end of a resume
    typedef struct packed {
        logic clear_status_flags;
        logic clear_wake_cause_hi;
        logic clear_enables;
    } wake_clear_t;

endpackage

/* verilog/clk_run_gate.sv */
// Gate of one MAC domain reset on the synchronised clock-running indication
`timescale 1ns/100ps
module clk_run_gate (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Control
    input wire logic hold_reset_i,
    input wire logic clk_running_i,
    // Domain reset
    output logic domain_reset_o
);

    logic sync1_reg;
    logic sync2_reg;

    // Clock-running comes from another domain's detector
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else begin
            sync1_reg <= clk_running_i;
            sync2_reg <= sync1_reg;
        end
    end

    // A stopped clock keeps its domain in reset so release is always seen by a live clock
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            domain_reset_o <= 1'b1;
        end else begin
            domain_reset_o <= hold_reset_i || !sync2_reg;
        end
    end

endmodule

/* verilog/power_mgmt_control.sv */
// Power management control register with transceiver reset sequencing and MAC domain resets
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/100ps
`include "pmc_map.svh"
module power_mgmt_control
    import pmc_pkg::*;
#(
    parameter int unsigned HOLD_SHORT_CYC = (`PMC_HOLD_SHORT_MS * `PMC_NS_PER_MS) / `PMC_CLK_PERIOD_NS,
    parameter int unsigned HOLD_LONG_CYC = (`PMC_HOLD_LONG_MS * `PMC_NS_PER_MS) / `PMC_CLK_PERIOD_NS,
    parameter int unsigned SETTLE_CYC = (`PMC_SETTLE_MS * `PMC_NS_PER_MS) / `PMC_CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,

    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,

    // Device resets and configuration loading
    input wire logic guarded_reset_i,
    input wire logic reset_protect_i,
    input wire logic cfg_osc_keep_i,
    input wire logic cfg_loading_i,
    input wire logic unconfigured_i,

    // Transceiver
    input wire logic xcvr_reset_request_i,
    output logic xcvr_reset_o,
    output logic xcvr_busy_o,
    output logic analog_ref_enable_o,

    // Suspend and oscillator
    input wire logic suspend_active_i,
    input wire logic unpowered_i,
    output sleep_level_t sleep_level_o,
    output logic oscillator_enable_o,

    // Wake events and resume
    input wire logic energy_eff_wake_event_i,
    input wire logic resume_done_i,
    input wire logic resume_remote_i,
    output logic energy_eff_wake_request_o,
    output wake_clear_t wake_clear_o,

    // MAC clock domains
    input wire logic rx_clk_running_i,
    input wire logic tx_clk_running_i,
    output logic mac_rx_reset_o,
    output logic mac_tx_reset_o,

    // Status
    output logic ready_o
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Levels zero and one share one behaviour
    function automatic sleep_level_t effective_level(input sleep_level_t lvl);
        effective_level = (lvl == sleep_level_one) ? sleep_level_zero : lvl;
    endfunction

    function automatic logic [31:0] pack_ctl(input ctl_fields_t f, input logic rdy);
        logic [31:0] w;

        w = 32'h0000_0000;
        w[`PMC_HOLD_REF_BIT] = f.hold_analog_ref_on;
        w[`PMC_OSC_KEEP_BIT] = f.oscillator_keep_running;
        w[`PMC_EEE_EN_BIT] = f.energy_eff_wake_enable;
        w[`PMC_EEE_FLAG_BIT] = f.energy_eff_wake_flag;
        w[`PMC_MAC_RST_BIT] = f.mac_domain_reset;
        w[`PMC_CLR_FLAGS_BIT] = f.resume_clears_wake_flags;
        w[`PMC_CLR_EN_BIT] = f.resume_clears_wake_enables;
        w[`PMC_READY_BIT] = rdy;
        w[`PMC_LEVEL_HI:`PMC_LEVEL_LO] = f.sleep_level;
        pack_ctl = w;
    endfunction

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    logic addr_hit;
    logic addr_phase;
    logic wr_pend_reg;
    logic wr_data_phase;
    logic [31:0] wdata;

    ctl_fields_t ctl_reg;
    logic ready_reg;

    // Any hsize is taken as a whole word
    assign addr_phase = hsel_i && hready_i && htrans_i[1];
    assign addr_hit = (haddr_i == `PMC_CTL_OFFSET);

    // Zero wait states, never an error: unmapped addresses read zero and ignore writes
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            wr_pend_reg <= 1'b0;
        end else if (hready_i) begin
            wr_pend_reg <= addr_phase && hwrite_i && addr_hit;
        end
    end

    assign wr_data_phase = wr_pend_reg;
    assign wdata = hwdata_i;

    // Read data is sampled in the address phase and stands through the data phase
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            hrdata_o <= 32'h0000_0000;
        end else if (addr_phase && !hwrite_i) begin
            hrdata_o <= addr_hit ? pack_ctl(ctl_reg, ready_reg) : 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // Resume handling
    // ----------------------------------------------------------------
    logic remote_resume_done;

    // Host resumes leave every wake bit alone
    assign remote_resume_done = resume_done_i && resume_remote_i;

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            wake_clear_o <= '0;
        end else begin
            wake_clear_o.clear_status_flags <= remote_resume_done && ctl_reg.resume_clears_wake_flags;
            wake_clear_o.clear_wake_cause_hi <= remote_resume_done && ctl_reg.resume_clears_wake_flags;
            wake_clear_o.clear_enables <= remote_resume_done && ctl_reg.resume_clears_wake_enables;
        end
    end

    // ----------------------------------------------------------------
    // Guarded fields
    // ----------------------------------------------------------------
    // A guarded reset leaves these alone when protection is on, else reloads them
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            ctl_reg.hold_analog_ref_on <= `PMC_HOLD_REF_RST;
            ctl_reg.oscillator_keep_running <= `PMC_OSC_KEEP_RST;
        end else if (guarded_reset_i) begin
            if (!reset_protect_i) begin
                ctl_reg.hold_analog_ref_on <= `PMC_HOLD_REF_RST;
                ctl_reg.oscillator_keep_running <= cfg_osc_keep_i;
            end
        end else if (wr_data_phase) begin
            ctl_reg.hold_analog_ref_on <= wdata[`PMC_HOLD_REF_BIT];
            ctl_reg.oscillator_keep_running <= wdata[`PMC_OSC_KEEP_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Wake enable and flag
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_b_i || guarded_reset_i) begin
            ctl_reg.energy_eff_wake_enable <= `PMC_EEE_EN_RST;
        end else if (remote_resume_done && ctl_reg.resume_clears_wake_enables) begin
            ctl_reg.energy_eff_wake_enable <= 1'b0;
        end else if (wr_data_phase) begin
            ctl_reg.energy_eff_wake_enable <= wdata[`PMC_EEE_EN_BIT];
        end
    end

    // An event in the same cycle as a clear keeps the flag set
    always_ff @(posedge clk_i) begin
        if (!rst_b_i || guarded_reset_i) begin
            ctl_reg.energy_eff_wake_flag <= `PMC_EEE_FLAG_RST;
        end else if (energy_eff_wake_event_i) begin
            ctl_reg.energy_eff_wake_flag <= 1'b1;
        end else if (remote_resume_done && ctl_reg.resume_clears_wake_flags) begin
            ctl_reg.energy_eff_wake_flag <= 1'b0;
        end else if (wr_data_phase && wdata[`PMC_EEE_FLAG_BIT]) begin
            ctl_reg.energy_eff_wake_flag <= 1'b0;
        end
    end

    assign energy_eff_wake_request_o = ctl_reg.energy_eff_wake_enable && ctl_reg.energy_eff_wake_flag;

    // ----------------------------------------------------------------
    // Plain control fields
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_b_i || guarded_reset_i) begin
            ctl_reg.mac_domain_reset <= `PMC_MAC_RST_RST;
            ctl_reg.resume_clears_wake_flags <= `PMC_CLR_FLAGS_RST;
            ctl_reg.resume_clears_wake_enables <= `PMC_CLR_EN_RST;
        end else if (wr_data_phase) begin
            ctl_reg.mac_domain_reset <= wdata[`PMC_MAC_RST_BIT];
            ctl_reg.resume_clears_wake_flags <= wdata[`PMC_CLR_FLAGS_BIT];
            ctl_reg.resume_clears_wake_enables <= wdata[`PMC_CLR_EN_BIT];
        end
    end

    // Dropping to unconfigured overrides a write in the same cycle
    always_ff @(posedge clk_i) begin
        if (!rst_b_i || guarded_reset_i) begin
            ctl_reg.sleep_level <= sleep_level_t'(`PMC_LEVEL_RST);
        end else if (unconfigured_i) begin
            ctl_reg.sleep_level <= sleep_level_t'(`PMC_LEVEL_RST);
        end else if (wr_data_phase) begin
            ctl_reg.sleep_level <= sleep_level_t'(wdata[`PMC_LEVEL_HI:`PMC_LEVEL_LO]);
        end
    end

    assign sleep_level_o = effective_level(ctl_reg.sleep_level);

    // ----------------------------------------------------------------
    // Oscillator
    // ----------------------------------------------------------------
    logic deep_sleep;

    // Only level two stops the crystal in suspend; the unpowered state stops it at any level
    assign deep_sleep = (suspend_active_i && ctl_reg.sleep_level == sleep_level_two) || unpowered_i;

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            oscillator_enable_o <= 1'b1;
        end else begin
            oscillator_enable_o <= ctl_reg.oscillator_keep_running || !deep_sleep;
        end
    end

    // ----------------------------------------------------------------
    // Transceiver reset sequence
    // ----------------------------------------------------------------
    xcvr_state_t xstate_reg;
    xcvr_state_t xstate_next;

    logic [31:0] xcnt_reg;
    logic [31:0] xcnt_next;

    logic ref_off_reg;
    logic [31:0] hold_len;

    // Switching the reference off saves power but costs the longer hold and the settle wait
    assign hold_len = ref_off_reg ? 32'(HOLD_LONG_CYC) : 32'(HOLD_SHORT_CYC);

    always_comb begin
        xstate_next = xstate_reg;
        xcnt_next = xcnt_reg + 32'h0000_0001;

        unique case (xstate_reg)
            xcvr_hold: begin
                if (xcnt_reg >= hold_len - 32'h0000_0001) begin
                    xstate_next = ref_off_reg ? xcvr_settle : xcvr_run;
                    xcnt_next = 32'h0000_0000;
                end
            end

            xcvr_settle: begin
                if (xcnt_reg >= 32'(SETTLE_CYC) - 32'h0000_0001) begin
                    xstate_next = xcvr_run;
                    xcnt_next = 32'h0000_0000;
                end
            end

            xcvr_run: begin
                xcnt_next = 32'h0000_0000;
                if (xcvr_reset_request_i) begin
                    xstate_next = xcvr_hold;
                end
            end
            default: begin
                xstate_next = xcvr_hold;
                xcnt_next = 32'h0000_0000;
            end
        endcase
    end

    // Requests during a running sequence are ignored
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            xstate_reg <= xcvr_hold;
            xcnt_reg <= 32'h0000_0000;
        end else begin
            xstate_reg <= xstate_next;
            xcnt_reg <= xcnt_next;
        end
    end

    // Reference state is latched when the hold starts so a mid-sequence write cannot shorten it
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            ref_off_reg <= !`PMC_HOLD_REF_RST;
        end else if (xstate_reg == xcvr_run && xcvr_reset_request_i) begin
            ref_off_reg <= !ctl_reg.hold_analog_ref_on;
        end
    end

    assign xcvr_reset_o = (xstate_reg == xcvr_hold);
    assign xcvr_busy_o = (xstate_reg != xcvr_run);
    assign analog_ref_enable_o = !(xstate_reg == xcvr_hold && ref_off_reg);

    // ----------------------------------------------------------------
    // Ready
    // ----------------------------------------------------------------
    // Follows the next state so ready rises as the sequence ends
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            ready_reg <= `PMC_READY_RST;
        end else begin
            ready_reg <= (xstate_next == xcvr_run) && !cfg_loading_i;
        end
    end

    assign ready_o = ready_reg;

    // ----------------------------------------------------------------
    // MAC domain resets
    // ----------------------------------------------------------------
    // One gate per clock domain
    clk_run_gate rx_gate (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .hold_reset_i(ctl_reg.mac_domain_reset),
        .clk_running_i(rx_clk_running_i),
        .domain_reset_o(mac_rx_reset_o)
    );

    clk_run_gate tx_gate (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .hold_reset_i(ctl_reg.mac_domain_reset),
        .clk_running_i(tx_clk_running_i),
        .domain_reset_o(mac_tx_reset_o)
    );

endmodule

/* dv/power_mgmt_control_sva.sv */
// Concurrent checks on the ports of the power management control block
`timescale 1ns/100ps
module power_mgmt_control_sva
    import pmc_pkg::*;
#(
    parameter int unsigned HOLD_SHORT_CYC = 4,
    parameter int unsigned HOLD_LONG_CYC = 8,
    parameter int unsigned SETTLE_CYC = 6
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Watched inputs
    input wire logic cfg_loading_i,
    input wire logic unconfigured_i,
    input wire logic xcvr_reset_request_i,
    input wire logic suspend_active_i,
    input wire logic unpowered_i,
    input wire logic resume_done_i,
    input wire logic resume_remote_i,
    input wire logic rx_clk_running_i,
    input wire logic tx_clk_running_i,
    // Watched outputs
    input wire logic xcvr_reset_o,
    input wire logic xcvr_busy_o,
    input wire logic analog_ref_enable_o,
    input sleep_level_t sleep_level_o,
    input wire logic oscillator_enable_o,
    input wake_clear_t wake_clear_o,
    input wire logic mac_rx_reset_o,
    input wire logic mac_tx_reset_o,
    input wire logic ready_o
);
// Repetition counts below assume the bench's short hold 4, long hold 8, settle 6
default clocking @(posedge clk_i); endclocking
default disable iff (!rst_b_i);

chk_host_no_clear: assert property (resume_done_i && !resume_remote_i |=> wake_clear_o == 3'h0)
    else $error("host resume produced a wake clear");
chk_clear_cause: assert property (wake_clear_o != 3'h0 |-> $past(resume_done_i) && $past(resume_remote_i))
    else $error("wake clear without a remote resume");
chk_flags_pair: assert property (wake_clear_o.clear_status_flags == wake_clear_o.clear_wake_cause_hi)
    else $error("status and cause clears disagree");
chk_rx_stopped: assert property (!rx_clk_running_i [*4] |-> mac_rx_reset_o)
    else $error("rx domain out of reset without clock");
chk_rx_release: assert property ($fell(mac_rx_reset_o) |-> $past(rx_clk_running_i, 3))
    else $error("rx reset released while clock stopped");
chk_tx_release: assert property ($fell(mac_tx_reset_o) |-> $past(tx_clk_running_i, 3))
    else $error("tx reset released while clock stopped");
chk_xcvr_take: assert property (xcvr_reset_request_i && !xcvr_busy_o |=> xcvr_reset_o && xcvr_busy_o && !ready_o)
    else $error("transceiver request not taken");
chk_short_hold: assert property ($rose(xcvr_reset_o) && analog_ref_enable_o |-> xcvr_reset_o [*4] ##1 !xcvr_busy_o)
    else $error("short hold length wrong");
chk_long_hold: assert property ($rose(xcvr_reset_o) && !analog_ref_enable_o |->
    xcvr_reset_o [*8] ##1 (!xcvr_reset_o && xcvr_busy_o) [*6] ##1 !xcvr_busy_o)
    else $error("long hold or settle length wrong");
chk_ready_busy: assert property (xcvr_busy_o |-> !ready_o)
    else $error("ready during transceiver sequence");
chk_ready_load: assert property ($past(cfg_loading_i) |-> !ready_o)
    else $error("ready while configuration loads");
chk_ref_in_reset: assert property (!analog_ref_enable_o |-> xcvr_reset_o)
    else $error("reference off outside transceiver reset");
chk_level_alias: assert property (sleep_level_o != sleep_level_one)
    else $error("level one not folded onto level zero");
chk_unconf_level: assert property (unconfigured_i |=> sleep_level_o == sleep_level_two)
    else $error("unconfigured did not restore level two");
chk_osc_awake: assert property (!suspend_active_i && !unpowered_i |=> oscillator_enable_o)
    else $error("oscillator off while awake");
endmodule

bind power_mgmt_control power_mgmt_control_sva #(.HOLD_SHORT_CYC(HOLD_SHORT_CYC), .HOLD_LONG_CYC(HOLD_LONG_CYC),
    .SETTLE_CYC(SETTLE_CYC)) power_mgmt_control_sva_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .cfg_loading_i(cfg_loading_i), .unconfigured_i(unconfigured_i), .xcvr_reset_request_i(xcvr_reset_request_i),
    .suspend_active_i(suspend_active_i), .unpowered_i(unpowered_i), .resume_done_i(resume_done_i),
    .resume_remote_i(resume_remote_i), .rx_clk_running_i(rx_clk_running_i), .tx_clk_running_i(tx_clk_running_i),
    .xcvr_reset_o(xcvr_reset_o), .xcvr_busy_o(xcvr_busy_o), .analog_ref_enable_o(analog_ref_enable_o),
    .sleep_level_o(sleep_level_o), .oscillator_enable_o(oscillator_enable_o), .wake_clear_o(wake_clear_o),
    .mac_rx_reset_o(mac_rx_reset_o), .mac_tx_reset_o(mac_tx_reset_o), .ready_o(ready_o));

/* dv/tb_top.sv */
// Self-checking bench of the power management control block
`timescale 1ns/100ps
`include "pmc_map.svh"
module tb_top;
import pmc_pkg::*;
// ----------------------------------------------------------------
// Signals
// ----------------------------------------------------------------
logic clk_i = 0, rst_b_i = 0, hsel = 0, hwrite = 0, g_rst = 0, prot = 0, osc_img = 0, loading = 0;
logic unconf = 0, xreq = 0, susp = 0, unpw = 0, ev = 0, rdone = 0, rremote = 0, rx_run = 1, tx_run = 1;
logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, w;
logic [1:0] htrans = 0;
logic [2:0] hsize = 3'h2;
logic hready, hresp, xrst, busy, aref, osc_en, wreq, mrx, mtx, ready;
sleep_level_t lvl;
wake_clear_t wclr;
int n_mismatch = 0, checked = 0, seed = 28495, n;

// Short counts keep each transceiver sequence to a few cycles
power_mgmt_control #(.HOLD_SHORT_CYC(4), .HOLD_LONG_CYC(8), .SETTLE_CYC(6)) power_mgmt_control_inst (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
    .hresp_o(hresp), .guarded_reset_i(g_rst), .reset_protect_i(prot), .cfg_osc_keep_i(osc_img),
    .cfg_loading_i(loading), .unconfigured_i(unconf), .xcvr_reset_request_i(xreq), .xcvr_reset_o(xrst),
    .xcvr_busy_o(busy), .analog_ref_enable_o(aref), .suspend_active_i(susp), .unpowered_i(unpw),
    .sleep_level_o(lvl), .oscillator_enable_o(osc_en), .energy_eff_wake_event_i(ev), .resume_done_i(rdone),
    .resume_remote_i(rremote), .energy_eff_wake_request_o(wreq), .wake_clear_o(wclr),
    .rx_clk_running_i(rx_run), .tx_clk_running_i(tx_run), .mac_rx_reset_o(mrx), .mac_tx_reset_o(mtx),
    .ready_o(ready));

always #2.5 clk_i = ~clk_i;

// ----------------------------------------------------------------
// Tasks
// ----------------------------------------------------------------
task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
        n_mismatch++;
        $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
endtask

task automatic tick(input int c = 1);
    repeat (c) @(posedge clk_i);
    #1;
endtask

// Single word transfer; the wait ends only on hready or the watchdog
task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_i);
    hsel <= 1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk_i); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_i); while (hready !== 1'b1);
    rd = hrdata;
    chk(hresp, 0);
    hsel <= 0;
endtask

function automatic logic [31:0] exp_rd(input logic [31:0] v, input logic flag, input logic rdy);
    return (v & 32'h0000_eb60) | {19'h0, flag, 4'h0, rdy, 7'h0};
endfunction

task automatic wait_rdy;
    n = 0;
    while (ready !== 1'b1 && n < 100) begin
        n++;
        tick();
    end
    chk(ready, 1);
endtask

task automatic resume(input logic [31:0] v, input logic remote);
    bus(1, `PMC_CTL_OFFSET, v);
    @(posedge clk_i) ev <= 1;
    @(posedge clk_i) ev <= 0;
    tick();
    chk(wreq, v[13]);
    @(posedge clk_i) rdone <= 1;
    rremote <= remote;
    @(posedge clk_i) rdone <= 0;
    #1 chk(wclr, remote ? {v[9], v[9], v[8]} : 3'h0);
    bus(0, `PMC_CTL_OFFSET, 0);
    chk(rd, exp_rd(v & ~{18'h0, remote & v[8], 13'h0}, !(remote & v[9]), 1));
    // Same suspend field in the clearing write
    bus(1, `PMC_CTL_OFFSET, v | 32'h1000);
    bus(0, `PMC_CTL_OFFSET, 0);
    chk(rd, exp_rd(v, 0, 1));
endtask

task automatic xcvr(input logic hold, input int exp_n);
    bus(1, `PMC_CTL_OFFSET, 32'h4140 | {hold, 15'h0});
    @(posedge clk_i) xreq <= 1;
    @(posedge clk_i) xreq <= 0;
    #1 chk({xrst, aref, ready}, {2'b11 & {1'b1, hold}, 1'b0});
    n = 0;
    while (busy === 1'b1 && n < 100) begin
        n++;
        tick();
    end
    chk(n, exp_n);
    wait_rdy();
endtask

task automatic finish_test;
    if (n_mismatch == 0 && checked > 0) begin
        $display("DONE - PASS");
    end else begin
        $display("DONE - FAIL");
    end
    $finish;
endtask

// ----------------------------------------------------------------
// Sequence
// ----------------------------------------------------------------
initial begin
    repeat (10) @(posedge clk_i);
    rst_b_i <= 1;
    wait_rdy();
    bus(0, `PMC_CTL_OFFSET, 0);
    chk(rd, 32'h0000_41c0);
    bus(0, 32'h18, 0);
    chk(rd, 0);
    for (int i = 0; i < 12; i++) begin
        w = i < 4 ? 32'h800 | (i << 5) : $random(seed) & ~32'h1000;
        bus(1, `PMC_CTL_OFFSET, w);
        bus(0, `PMC_CTL_OFFSET, 0);
        chk(rd, exp_rd(w, 0, 1));
        tick(2);
        chk({mrx, mtx}, {2{w[11]}});
        chk(lvl, w[6:5] == 2'h1 ? 2'h0 : w[6:5]);
    end
    bus(1, `PMC_CTL_OFFSET, 32'h4140);
    @(posedge clk_i) rx_run <= 0;
    tick(5);
    chk({mrx, mtx}, 2'b10);
    @(posedge clk_i) rx_run <= 1;
    tx_run <= 0;
    tick(5);
    chk({mrx, mtx}, 2'b01);
    @(posedge clk_i) tx_run <= 1;
    resume(32'h2340, 1);
    resume(32'h0340, 0);
    resume(32'h2040, 1);
    resume(32'h2240, 1);
    resume(32'h2140, 1);
    xcvr(1, 4);
    xcvr(0, 14);
    @(posedge clk_i) loading <= 1;
    tick(2);
    chk(ready, 0);
    @(posedge clk_i) loading <= 0;
    wait_rdy();
    for (int p = 1; p >= 0; p--) begin
        bus(1, `PMC_CTL_OFFSET, 32'h8060 | (p << 14));
        @(posedge clk_i) g_rst <= 1;
        prot <= p[0];
        osc_img <= !p[0];
        @(posedge clk_i) g_rst <= 0;
        bus(0, `PMC_CTL_OFFSET, 0);
        chk({rd[15:14], rd[8], rd[6:5]}, {p[0], p[0] | osc_img, 3'b110});
    end
    bus(1, `PMC_CTL_OFFSET, 32'h4160);
    @(posedge clk_i) unconf <= 1;
    @(posedge clk_i) unconf <= 0;
    bus(0, `PMC_CTL_OFFSET, 0);
    chk(rd[6:5], 2'h2);
    bus(1, `PMC_CTL_OFFSET, 32'h0040);
    susp <= 1;
    tick(2);
    chk(osc_en, 0);
    bus(1, `PMC_CTL_OFFSET, 32'h4040);
    tick(2);
    chk(osc_en, 1);
    @(posedge clk_i) susp <= 0;
    unpw <= 1;
    bus(1, `PMC_CTL_OFFSET, 32'h0040);
    tick(2);
    chk(osc_en, 0);
    @(posedge clk_i) unpw <= 0;
    tick(2);
    chk(osc_en, 1);
    finish_test();
end

initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    finish_test();
end
endmodule
